// file: rtl/asm_adc_status_mode_registers.sv
// Identification, status and global mode registers of a two-channel converter.
// Assumes the serial frame decoder presents single-cycle register strobes and
// that all event inputs are synchronous pulses or levels on clock_in.
`timescale 1ns/100ps
// Function
// - Identification low byte read-only, revision dependent
// - Status bit 15 shows interface lock
// - Status bit 14 set on each resync
// - Status bit 13 flags register-map checksum change
// - Status bit 12 flags input checksum error
// - Mode bit 11 picks polynomial, status mirrors
// - Status bit 10 reset flag, one after reset
// - Writing mode bit 10 zero clears flag
// - Mode bits 9:8 word length, status mirrors
// - Status bits 1:0 per-channel new data
// - Mode bit 13 enables register-map checksum
// - Mode bit 12 enables input checksum checking
// - Mode register resets to 0510h
// - Status register reads 0500h after reset
// - Mode bits 3:2 choose ready pin source
// - Mode bit 1 idle pin high or float
// - Mode bit 0 level or fixed pulse
module asm_adc_status_mode_registers
  #(parameter logic [7:0] ID_CODE      = 8'h5a, // Arbitrary value
    parameter logic [7:0] ID_REVISION  = 8'h01, // Arbitrary value
    parameter int         PULSE_CYCLES = asm_pkg::READY_PULSE_CYCLES)
  (
  // Clock and reset
  input  wire  logic                            clock_in,
  input  wire  logic                            rst_in,
  // Register access from the serial frame decoder
  input  wire  asm_pkg::asm_reg_req_t           reg_req_in,
  output asm_pkg::asm_word_t                    reg_rdata_out,
  output logic                                  reg_rvalid_out,
  // Interface and converter events
  input  wire  logic                            spi_locked_in,
  input  wire  logic                            resync_event_in,
  input  wire  logic                            rx_crc_error_in,
  input  wire  asm_pkg::asm_word_t              regmap_crc_in,
  input  wire  logic                            regmap_crc_valid_in,
  input  wire  logic [asm_pkg::NUM_CHAN-1:0]    chan_new_data_in,
  input  wire  logic [asm_pkg::NUM_CHAN-1:0]    chan_enable_in,
  input  wire  logic                            data_frame_read_in,
  // Configuration to the rest of the device
  output asm_pkg::asm_mode_t                    mode_cfg_out,
  // Conversion-ready pin
  output logic                                  conversion_ready_pin_out,
  output logic                                  conversion_ready_pin_oe_out
  );
  import asm_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_mode;
  logic rd_status;
  logic rd_any;

  assign wr_mode   = reg_req_in.wr && (reg_req_in.addr == OFS_GLOBAL_MODE_SETTINGS);
  assign rd_status = reg_req_in.rd && (reg_req_in.addr == OFS_DEVICE_STATUS_FLAGS);
  assign rd_any    = reg_req_in.rd;

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // Reserved bits are stored and read back as written
  asm_mode_t mode_ff;
  asm_mode_t nxt_mode;
  asm_mode_t wr_val;

  assign wr_val = asm_mode_t'(reg_req_in.wdata);

  always_comb
  begin
    nxt_mode = mode_ff;
    if (wr_mode)
    begin
      nxt_mode = wr_val;
      // Reset flag can only be cleared by software, never set
      nxt_mode.reset_flag = mode_ff.reset_flag && wr_val.reset_flag;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      mode_ff <= asm_mode_t'(MODE_RESET);
    else
      mode_ff <= nxt_mode;
  end

  assign mode_cfg_out = mode_ff;

  // ----------------------------------------------------------------
  // Lock indicator
  // ----------------------------------------------------------------
  // Registered so a status read never sees a half-settled level
  logic lock_ff;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      lock_ff <= 1'b0;
    else
      lock_ff <= spi_locked_in;
  end

  // ----------------------------------------------------------------
  // Sticky event flags, cleared by a status read; a set wins
  // ----------------------------------------------------------------
  logic resync_ff;
  logic crc_err_ff;
  logic regmap_chg_ff;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      resync_ff <= 1'b0;
    else if (resync_event_in)
      resync_ff <= 1'b1;
    else if (rd_status)
      resync_ff <= 1'b0;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      crc_err_ff <= 1'b0;
    else if (rx_crc_error_in && mode_ff.rx_crc_en)
      crc_err_ff <= 1'b1;
    else if (rd_status)
      crc_err_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Register-map checksum watch
  // ----------------------------------------------------------------
  // A host write changes the map on purpose, so the reference is
  // dropped and re-taken from the next computed value.
  asm_word_t crc_ref_ff;
  logic      crc_ref_valid_ff;
  logic      crc_mismatch;

  assign crc_mismatch = mode_ff.regmap_crc_en && regmap_crc_valid_in &&
                        crc_ref_valid_ff && (regmap_crc_in != crc_ref_ff);

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      crc_ref_ff <= READ_ZERO;
    else if (mode_ff.regmap_crc_en && regmap_crc_valid_in)
      crc_ref_ff <= regmap_crc_in;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      crc_ref_valid_ff <= 1'b0;
    else if (!mode_ff.regmap_crc_en || reg_req_in.wr)
      crc_ref_valid_ff <= 1'b0;
    else if (regmap_crc_valid_in)
      crc_ref_valid_ff <= 1'b1;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      regmap_chg_ff <= 1'b0;
    else if (crc_mismatch)
      regmap_chg_ff <= 1'b1;
    else if (rd_status)
      regmap_chg_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Per-channel new-data flags
  // ----------------------------------------------------------------
  // Disabled channels never set, so enabling later shows no stale data
  logic [NUM_CHAN-1:0] new_data_ff;

  generate
    for (genvar ch = 0; ch < NUM_CHAN; ch++)
    begin : g_chan
      always_ff @(posedge clock_in or posedge rst_in)
      begin
        if (rst_in)
          new_data_ff[ch] <= 1'b0;
        else if (chan_new_data_in[ch] && chan_enable_in[ch])
          new_data_ff[ch] <= 1'b1;
        else if (data_frame_read_in)
          new_data_ff[ch] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  asm_status_t status;

  always_comb
  begin
    // Reserved bits read zero
    status                   = asm_status_t'(READ_ZERO);
    status.lock              = lock_ff;
    status.resync_event_flag = resync_ff;
    status.regmap_changed    = regmap_chg_ff;
    status.rx_crc_error      = crc_err_ff;
    status.crc_type          = mode_ff.crc_type;
    status.reset_flag        = mode_ff.reset_flag;
    status.word_size_select  = mode_ff.word_size_select;
    status.new_data_flag     = new_data_ff;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data hold the last answer; only rvalid marks a fresh one
  asm_word_t rd_mux;

  always_comb
  begin
    rd_mux = READ_ZERO;
    case (reg_req_in.addr)
      OFS_DEVICE_IDENTIFICATION:
        rd_mux = {ID_CODE, ID_REVISION};
      OFS_DEVICE_STATUS_FLAGS:
        rd_mux = asm_word_t'(status);
      OFS_GLOBAL_MODE_SETTINGS:
        rd_mux = asm_word_t'(mode_ff);
      default:
        rd_mux = READ_ZERO;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= READ_ZERO;
    else if (rd_any)
      reg_rdata_out <= rd_mux;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rvalid_out <= 1'b0;
    else
      reg_rvalid_out <= rd_any;
  end

  // ----------------------------------------------------------------
  // Read-only registers
  // ----------------------------------------------------------------
  // Identification and status have no write path: only wr_mode is
  // decoded, so other writes merely drop the checksum reference.

  // ----------------------------------------------------------------
  // Ready source selection
  // ----------------------------------------------------------------
  // Channels sample together, so leading and OR share one path: both
  // select any_ready and assert on the first enabled flag.
  logic [NUM_CHAN-1:0] en_flags;
  logic                any_enabled;
  logic                all_ready;
  logic                any_ready;
  logic                ready_level;

  assign en_flags    = new_data_ff & chan_enable_in;
  assign any_enabled = |chan_enable_in;
  assign all_ready   = any_enabled && ((new_data_ff | ~chan_enable_in) == '1);
  assign any_ready   = |en_flags;

  always_comb
  begin
    ready_level = any_ready;
    unique case (mode_ff.ready_pin_source_select)
      SEL_LAGGING:
        ready_level = all_ready;
      SEL_OR_ALL:
        ready_level = any_ready;
      default:
        ready_level = any_ready;
    endcase
  end

  asm_ready_pin
    #(.PULSE_CYCLES (PULSE_CYCLES))
  u_ready_pin
    (
    .clock_in        (clock_in),
    .rst_in          (rst_in),
    .ready_level_in  (ready_level),
    .idle_float_in   (mode_ff.ready_pin_idle_float),
    .pulse_format_in (mode_ff.ready_pin_pulse_format),
    .pin_out         (conversion_ready_pin_out),
    .pin_oe_out      (conversion_ready_pin_oe_out)
    );

endmodule

// file: rtl/asm_pkg.sv
// Shared constants and types of the converter status and mode register bank.
// Assumes a 100 MHz device clock and 16-bit register words.
package asm_pkg;

  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 6;
  localparam int          DATA_W         = 16;
  localparam int          NUM_CHAN       = 2;
  localparam int          CLK_PERIOD_NS  = 10;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_DEVICE_IDENTIFICATION = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_DEVICE_STATUS_FLAGS   = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_MODE_SETTINGS  = 6'h02;

  // ----------------------------------------------------------------
  // Reset values and field codes
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] MODE_RESET     = 16'h0510;
  localparam logic [DATA_W-1:0] STATUS_RESET   = 16'h0500;
  localparam logic [DATA_W-1:0] READ_ZERO      = 16'h0000;
  localparam logic [1:0]        SEL_LAGGING    = 2'h0;
  localparam logic [1:0]        SEL_OR_ALL     = 2'h1;
  localparam logic [1:0]        WORD_16        = 2'h0;
  localparam logic [1:0]        WORD_24        = 2'h1;
  localparam logic [1:0]        WORD_32_ZERO   = 2'h2;
  localparam logic [1:0]        WORD_32_SIGN   = 2'h3;

  // ----------------------------------------------------------------
  // Ready pulse timing
  // ----------------------------------------------------------------
  localparam int READY_PULSE_NS     = 40;
  localparam int READY_PULSE_CYCLES =
    ((READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [DATA_W-1:0] asm_word_t;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [ADDR_W-1:0] addr;
    asm_word_t        wdata;
  } asm_reg_req_t;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       regmap_crc_en;
    logic       rx_crc_en;
    logic       crc_type;
    logic       reset_flag;
    logic [1:0] word_size_select;
    logic [2:0] rsvd_lo;
    logic       timeout_en;
    logic [1:0] ready_pin_source_select;
    logic       ready_pin_idle_float;
    logic       ready_pin_pulse_format;
  } asm_mode_t;

  typedef struct packed {
    logic                lock;
    logic                resync_event_flag;
    logic                regmap_changed;
    logic                rx_crc_error;
    logic                crc_type;
    logic                reset_flag;
    logic [1:0]          word_size_select;
    logic [5:0]          rsvd;
    logic [NUM_CHAN-1:0] new_data_flag;
  } asm_status_t;

  typedef enum logic [3:0] {
    RP_IDLE  = 4'b0001,
    RP_LEVEL = 4'b0010,
    RP_PULSE = 4'b0100,
    RP_SPENT = 4'b1000
  } asm_ready_state_t;

endpackage

// file: rtl/asm_ready_pin.sv
// Drives the conversion-ready pin from the combined data-ready level.
// Assumes ready_level_in is synchronous to clock_in and drops when data are read.
`timescale 1ns/100ps
module asm_ready_pin
  #(parameter int PULSE_CYCLES = asm_pkg::READY_PULSE_CYCLES)
  (
  // Clock and reset
  input  wire  logic clock_in,
  input  wire  logic rst_in,
  // Control
  input  wire  logic ready_level_in,
  input  wire  logic idle_float_in,
  input  wire  logic pulse_format_in,
  // Pin
  output logic       pin_out,
  output logic       pin_oe_out
  );
  import asm_pkg::*;

  localparam int CNT_W = (PULSE_CYCLES < 2) ? 1 : $clog2(PULSE_CYCLES);

  asm_ready_state_t state_ff;
  asm_ready_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             drive_low;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      RP_IDLE:
      begin
        if (ready_level_in)
        begin
          nxt_cnt   = '0;
          nxt_state = pulse_format_in ? RP_PULSE : RP_LEVEL;
        end
      end
      RP_LEVEL:
      begin
        if (!ready_level_in)
          nxt_state = RP_IDLE;
      end
      RP_PULSE:
      begin
        // Fixed width even if data are read early
        if (cnt_ff == CNT_W'(PULSE_CYCLES - 1))
          nxt_state = ready_level_in ? RP_SPENT : RP_IDLE;
        else
          nxt_cnt = cnt_ff + 1'b1;
      end
      RP_SPENT:
      begin
        if (!ready_level_in)
          nxt_state = RP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      state_ff <= RP_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign drive_low  = (state_ff == RP_LEVEL) || (state_ff == RP_PULSE);
  assign pin_out    = !drive_low;
  assign pin_oe_out = drive_low || !idle_float_in;

endmodule

// file: test/asm_status_mode_checker.sv
// Concurrent checks on the status and mode register bank ports.
// Assumes one clock domain and the default ready pulse length handed on by bind.
`timescale 1ns/100ps
module asm_status_mode_checker
  import asm_pkg::*;
  #(parameter int PULSE_CYCLES = 4)
  (
  // Clock and reset
  input  wire  logic                 clock_in,
  input  wire  logic                 rst_in,
  // Register access
  input  wire  asm_pkg::asm_reg_req_t reg_req_in,
  input  wire  asm_pkg::asm_word_t   reg_rdata_out,
  input  wire  logic                 reg_rvalid_out,
  // Events and outputs
  input  wire  logic                 spi_locked_in,
  input  wire  asm_pkg::asm_mode_t   mode_cfg_out,
  input  wire  logic                 conversion_ready_pin_out,
  input  wire  logic                 conversion_ready_pin_oe_out
  );
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic rd_st;
  logic rd_md;
  logic [7:0] low_cnt_ff;
  assign rd_st = reg_req_in.rd && reg_req_in.addr == OFS_DEVICE_STATUS_FLAGS;
  assign rd_md = reg_req_in.rd && reg_req_in.addr == OFS_GLOBAL_MODE_SETTINGS;
  // ----------------------------------------------------------------
  // Length of the last low stretch on the ready pin
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      low_cnt_ff <= 8'h00;
    else
      low_cnt_ff <= conversion_ready_pin_out ? 8'h00 : low_cnt_ff + 8'h01;
  a_read_answer_one: assert property (reg_req_in.rd |=> reg_rvalid_out)
    else $error("read without answer");
  a_no_stray_valid: assert property (!reg_req_in.rd |=> !reg_rvalid_out)
    else $error("answer without read");
  a_mode_write_applies: assert property (
    reg_req_in.wr && reg_req_in.addr == OFS_GLOBAL_MODE_SETTINGS |=>
    mode_cfg_out == {$past(reg_req_in.wdata[15:11]),
      $past(reg_req_in.wdata[10] & mode_cfg_out[10]), $past(reg_req_in.wdata[9:0])})
    else $error("mode write wrong");
  a_other_write_kept: assert property (
    reg_req_in.wr && reg_req_in.addr != OFS_GLOBAL_MODE_SETTINGS |=> $stable(mode_cfg_out))
    else $error("mode changed by other write");
  a_mode_read_back: assert property (rd_md |=> reg_rdata_out == $past(mode_cfg_out))
    else $error("mode read wrong");
  a_status_mirror: assert property (
    rd_st |=> reg_rdata_out[11:2] == {$past(mode_cfg_out[11:8]), 6'h00})
    else $error("status mirror wrong");
  a_lock_shown: assert property (
    rd_st && $stable(spi_locked_in) |=> reg_rdata_out[15] == $past(spi_locked_in))
    else $error("lock bit wrong");
  a_unmapped_zero: assert property (
    reg_req_in.rd && reg_req_in.addr > OFS_GLOBAL_MODE_SETTINGS |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_float_idle: assert property (
    !conversion_ready_pin_oe_out |-> mode_cfg_out.ready_pin_idle_float)
    else $error("pin floated while not allowed");
  a_pulse_width: assert property (
    $rose(conversion_ready_pin_out) && mode_cfg_out.ready_pin_pulse_format &&
    $past(mode_cfg_out.ready_pin_pulse_format) |-> low_cnt_ff == PULSE_CYCLES)
    else $error("ready pulse length wrong");
  c_status_read: cover property (rd_st);
  c_mode_write: cover property (reg_req_in.wr && reg_req_in.addr == OFS_GLOBAL_MODE_SETTINGS);
  c_pulse: cover property ($rose(conversion_ready_pin_out) && mode_cfg_out.ready_pin_pulse_format);
endmodule

bind asm_adc_status_mode_registers asm_status_mode_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk
  (.clock_in(clock_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
   .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
   .spi_locked_in(spi_locked_in), .mode_cfg_out(mode_cfg_out),
   .conversion_ready_pin_out(conversion_ready_pin_out),
   .conversion_ready_pin_oe_out(conversion_ready_pin_oe_out));

// file: test/asm_host_model.sv
// Host side of the register port: one-cycle read and write strobes.
// Assumes the answer arrives exactly one cycle after the taking edge.
`timescale 1ns/100ps
module asm_host_model
  import asm_pkg::*;
  (
  // Clock
  input  wire  logic                 clock_in,
  // Register port
  output asm_pkg::asm_reg_req_t      req_out,
  input  wire  asm_pkg::asm_word_t   rdata_in,
  input  wire  logic                 rvalid_in
  );
  initial req_out = '0;
  // Idle address and data are inverted so stale values never look valid
  task automatic access(input logic w, input logic [5:0] a, input asm_word_t d,
                        output asm_word_t q);
    @(posedge clock_in);
    req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = 'x;
    if (!w)
    begin
      @(posedge clock_in);
      q = rvalid_in ? rdata_in : 'x;
    end
  endtask
endmodule

// file: test/asm_adc_status_mode_registers_tb.sv
// Sequence tests of the status and mode register bank through the host model.
// Assumes default ready pulse length of four cycles.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module asm_adc_status_mode_registers_tb;
  import asm_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic lock = 1'b0, resync = 1'b0, rx_err = 1'b0, crc_v = 1'b0, frame_rd = 1'b0;
  logic [1:0] new_d = 2'h0, chen = 2'h3;
  asm_word_t crc = 16'h0000, q, id_val, rdata;
  asm_reg_req_t req;
  asm_mode_t mode;
  logic rvalid, pin, pin_oe;
  int miscompares = 0, checked = 0, n;
  always #5 clock_in = ~clock_in;
  asm_host_model host (.clock_in(clock_in), .req_out(req), .rdata_in(rdata), .rvalid_in(rvalid));
  asm_adc_status_mode_registers uut (.clock_in(clock_in), .rst_in(rst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .spi_locked_in(lock),
    .resync_event_in(resync), .rx_crc_error_in(rx_err), .regmap_crc_in(crc),
    .regmap_crc_valid_in(crc_v), .chan_new_data_in(new_d), .chan_enable_in(chen),
    .data_frame_read_in(frame_rd), .mode_cfg_out(mode),
    .conversion_ready_pin_out(pin), .conversion_ready_pin_oe_out(pin_oe));
  task automatic rd(input logic [5:0] a, output asm_word_t v);
    host.access(1'b0, a, 16'h0000, v);
  endtask
  task automatic wr(input logic [5:0] a, input asm_word_t d);
    asm_word_t v;
    host.access(1'b1, a, d, v);
  endtask
  // Resync, input error and two differing map checksums in a burst
  task automatic fire();
    @(posedge clock_in);
    resync <= 1'b1; rx_err <= 1'b1; crc_v <= 1'b1; crc <= 16'h1234;
    @(posedge clock_in);
    resync <= 1'b0; rx_err <= 1'b0; crc <= 16'h4321;
    @(posedge clock_in);
    crc_v <= 1'b0;
  endtask
  task automatic pulse_data(input logic [1:0] ch);
    @(posedge clock_in);
    new_d <= ch;
    @(posedge clock_in);
    new_d <= 2'h0;
    repeat (3) @(posedge clock_in);
  endtask
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clock_in);
    miscompares++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(OFS_GLOBAL_MODE_SETTINGS, q); `CHK(q, MODE_RESET)
    rd(OFS_DEVICE_STATUS_FLAGS, q); `CHK(q, STATUS_RESET)
    rd(OFS_DEVICE_IDENTIFICATION, id_val);
    wr(OFS_DEVICE_IDENTIFICATION, ~id_val);
    wr(OFS_DEVICE_STATUS_FLAGS, 16'hffff);
    rd(OFS_DEVICE_IDENTIFICATION, q); `CHK(q, id_val)
    rd(OFS_DEVICE_STATUS_FLAGS, q); `CHK(q, STATUS_RESET)
    rd(6'h3f, q); `CHK(q, READ_ZERO)
    for (int w = 0; w < 4; w++)
    begin
      wr(OFS_GLOBAL_MODE_SETTINGS, {4'h0, w[0], 1'b0, w[1:0], 8'h10});
      rd(OFS_DEVICE_STATUS_FLAGS, q); `CHK(q[11:8], {w[0], 1'b0, w[1:0]})
    end
    wr(OFS_GLOBAL_MODE_SETTINGS, 16'h3510);
    rd(OFS_GLOBAL_MODE_SETTINGS, q); `CHK(q, 16'h3110)
    lock <= 1'b1;
    fire();
    rd(OFS_DEVICE_STATUS_FLAGS, q); `CHK(q[15:12], 4'hf)
    rd(OFS_DEVICE_STATUS_FLAGS, q); `CHK(q[15:12], 4'h8)
    wr(OFS_GLOBAL_MODE_SETTINGS, 16'h0100);
    fire();
    rd(OFS_DEVICE_STATUS_FLAGS, q); `CHK(q[14:12], 3'h4)
    rd(OFS_GLOBAL_MODE_SETTINGS, q); `CHK(q[4], 1'b0)
    pulse_data(2'h1);
    rd(OFS_DEVICE_STATUS_FLAGS, q); `CHK(q[1:0], 2'h1)
    `CHK(pin, 1'b1)
    wr(OFS_GLOBAL_MODE_SETTINGS, 16'h0104);
    repeat (2) @(posedge clock_in);
    `CHK(pin, 1'b0)
    chen <= 2'h1;
    pulse_data(2'h2);
    rd(OFS_DEVICE_STATUS_FLAGS, q); `CHK(q[1:0], 2'h1)
    chen <= 2'h3;
    @(posedge clock_in);
    frame_rd <= 1'b1;
    @(posedge clock_in);
    frame_rd <= 1'b0;
    repeat (2) @(posedge clock_in);
    `CHK({pin, pin_oe}, 2'h3)
    wr(OFS_GLOBAL_MODE_SETTINGS, 16'h0106);
    @(posedge clock_in);
    `CHK(pin_oe, 1'b0)
    wr(OFS_GLOBAL_MODE_SETTINGS, 16'h0105);
    @(posedge clock_in);
    new_d <= 2'h1;
    @(posedge clock_in);
    new_d <= 2'h0;
    n = 0;
    repeat (12)
    begin
      @(posedge clock_in);
      n += (pin === 1'b0);
    end
    `CHK(n, READY_PULSE_CYCLES)
    print_verdict();
  end
endmodule
